// file: src/mmd_pkg.sv
// Purpose: Shared constants and types for the opcode decode and execute block.
// Assumes: 16-bit words, word-addressed memory, one processor clock.
// Notes: Byte 0 is the low byte of a word, byte 1 the high byte.
`default_nettype none
package mmd_pkg;

  // ----------------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------------
  localparam int W = 16;
  localparam int PTR_CHAIN_BIT = 15;
  localparam logic [15:0] PTR_ADDR_MASK = 16'h7FFF;

  // ----------------------------------------------------------------------
  // Memory-reference groups, instruction bits 15:11
  // ----------------------------------------------------------------------
  localparam logic [4:0] G_AND = 5'h10;
  localparam logic [4:0] G_ADD = 5'h11;
  localparam logic [4:0] G_IOR = 5'h14;
  localparam logic [4:0] G_XOR = 5'h15;
  localparam logic [4:0] G_EMA = 5'h17;
  localparam logic [4:0] G_CMS = 5'h1A;

  // Addressing code, bits 10:8: bit 0 is indirect, bits 2:1 the base.
  localparam logic [1:0] AB_SCRATCH = 2'h0;
  localparam logic [1:0] AB_PC_FWD = 2'h1;
  localparam logic [1:0] AB_INDEXED = 2'h2;
  localparam logic [1:0] AB_PC_BACK = 2'h3;
  localparam logic [2:0] AM_BYTE1 = 3'h6;

  // ----------------------------------------------------------------------
  // Prefix codes, instruction bits 15:8
  // ----------------------------------------------------------------------
  localparam logic [7:0] P_CMP_ACC = 8'hC0;
  localparam logic [7:0] P_CMP_IDX = 8'hC1;
  localparam logic [7:0] P_ADD_IDX = 8'hC2;
  localparam logic [7:0] P_BLK_IN = 8'h71;
  localparam logic [7:0] P_BLK_OUT = 8'h75;

  // ----------------------------------------------------------------------
  // Shifts: count field in bits 2:0
  // ----------------------------------------------------------------------
  localparam logic [15:0] SH_MASK = 16'hFFF8;
  localparam logic [15:0] SH_ACC_L = 16'h1050;
  localparam logic [15:0] SH_ACC_R = 16'h10D0;
  localparam logic [15:0] SH_IDX_L = 16'h1028;
  localparam logic [15:0] SH_IDX_R = 16'h10A8;

  // ----------------------------------------------------------------------
  // Fixed register codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] F_MASK_ACC = 16'h0070;
  localparam logic [15:0] F_MASK_IDX = 16'h0068;
  localparam logic [15:0] F_NOR_ACC = 16'h0060;
  localparam logic [15:0] F_NEG_ACC = 16'h0110;
  localparam logic [15:0] F_INV_ACC = 16'h0210;
  localparam logic [15:0] F_INV_BOTH = 16'h0208;
  localparam logic [15:0] F_INV_IDX = 16'h0408;
  localparam logic [15:0] F_INVX_ACC = 16'h0410;
  localparam logic [15:0] F_ACC_M1 = 16'h0010;
  localparam logic [15:0] F_BOTH_M1 = 16'h0018;
  localparam logic [15:0] F_ACC_P1 = 16'h0350;
  localparam logic [15:0] F_BOTH_P1 = 16'h0358;
  localparam logic [15:0] F_DEC_ACC = 16'h00D0;
  localparam logic [15:0] F_DEC_IDX = 16'h00A8;
  localparam logic [15:0] F_DECA_IDX = 16'h00C8;
  localparam logic [15:0] F_DECX_ACC = 16'h00B0;

  localparam logic [15:0] ONE = 16'h0001;
  localparam logic [15:0] TWO = 16'h0002;

  typedef enum logic [1:0] {ALU_AND, ALU_OR, ALU_XOR, ALU_ADD} mmd_alu_op_t;

  typedef enum logic [3:0] {
    ST_FETCH, ST_FWAIT, ST_EXEC, ST_PTR, ST_OPND, ST_WRITE,
    ST_SHIFT, ST_BASE, ST_SENSE, ST_BRD, ST_BWR
  } mmd_state_t;

endpackage
`default_nettype wire

// file: src/mmd_alu.sv
// Purpose: Combining logic for accumulator and memory operands.
// Assumes: Operands already selected and byte-extended by the caller.
// Notes: Purely combinational; the caller registers every result.
`default_nettype none
module mmd_alu (
  input wire mmd_pkg::mmd_alu_op_t op,
  input wire logic [15:0] a,
  input wire logic [15:0] m,
  output logic [15:0] res,
  output logic m_ge_a
);

  always_comb begin
    case (op)
      mmd_pkg::ALU_AND: res = a & m; // RQ4 RQ5
      mmd_pkg::ALU_OR: res = a | m; // RQ5 RQ22
      mmd_pkg::ALU_XOR: res = a ^ m; // RQ5
      default: res = a + m; // RQ3
    endcase
  end

  // Signed ordering, so a negative memory word is below a positive one.
  assign m_ge_a = $signed(m) >= $signed(a); // RQ15

endmodule
`default_nettype wire

// file: src/mmd_core.sv
// Purpose: Decode and execute for memory-reference, register and block I/O codes.
// Assumes: Memory on the same clock answering with a one-cycle mem_ack.
// Notes: Each memory access is one request held until acknowledged.
//
// Operation
// (RQ1) Starred codes have operand fields; unstarred codes must match the whole word.
// (RQ2) Three bits below a memory base code select one of eight addressing forms.
// (RQ3) Word add puts accumulator plus memory into accumulator; indirection adds cycles.
// (RQ4) Word AND puts accumulator AND memory into accumulator, same timing as add.
// (RQ5) OR, XOR and AND combine every bit; result stays in the accumulator.
// (RQ6) Register NOR puts NOR of accumulator and index into accumulator.
// (RQ7) Code 0070 ANDs into accumulator, 0068 into index, one cycle each.
// (RQ8) Complement codes invert accumulator, both, index, or index into accumulator.
// (RQ9) Accumulator complement flips every bit.
// (RQ10) Negate replaces the accumulator with its two's-complement negative.
// (RQ11) Constant loads set accumulator or both registers to minus or plus one.
// (RQ12) Decrement codes for accumulator, index, and cross-register forms.
// (RQ13) Arithmetic shifts of either register, one bit per step, by count field; the code shifts count plus one bits.
// (RQ14) Immediate compare to accumulator or index, and immediate add to index.
// (RQ15) Compare memory with accumulator and skip when memory is high or equal.
// (RQ16) Exchange swaps memory word and accumulator.
// (RQ17) Byte forms take one pointer level only when indirect.
// (RQ18) Byte code 2 is byte 0 and code 6 byte 1, both forward from P.
// (RQ19) Block input 7100 and block output 7500 with per-word transfers.
// (RQ20) Block output sends memory words on sense instead of storing bus data.
// (RQ21) Index holds count, base follows instruction, wait for sense, skip two.
// (RQ22) Word inclusive OR ORs memory into accumulator over eight forms.
// (RQ23) Word pointers chain while their top bit is set, one access each.
`default_nettype none
module mmd_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic byte_mode,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic [7:0] io_dev,
  output logic io_sel,
  output logic io_strobe,
  output logic [15:0] io_dout,
  input wire logic io_sense,
  input wire logic [15:0] io_din,
  output logic [15:0] acc,
  output logic [15:0] idx,
  output logic [15:0] pc
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic sense_m_q;
  logic sense_s_q;
  logic sense_d_q;
  logic bm_m_q;
  logic bm_s_q;
  logic [15:0] din_m_q;
  logic [15:0] din_s_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_m_q <= 1'b0;
      sense_s_q <= 1'b0;
      sense_d_q <= 1'b0;
      bm_m_q <= 1'b0;
      bm_s_q <= 1'b0;
      din_m_q <= 16'h0000;
      din_s_q <= 16'h0000;
    end else if (ce) begin
      sense_m_q <= io_sense;
      sense_s_q <= sense_m_q;
      sense_d_q <= sense_s_q;
      bm_m_q <= byte_mode;
      bm_s_q <= bm_m_q;
      din_m_q <= io_din;
      din_s_q <= din_m_q;
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  mmd_pkg::mmd_state_t state_q;
  logic [15:0] ir_q;
  logic [15:0] a_q;
  logic [15:0] x_q;
  logic [15:0] p_q;
  logic [15:0] base_q;
  logic [2:0] cnt_q;
  logic bsel_q;
  logic bmode_q;
  logic pend_q;
  logic mem_rd_q;
  logic mem_wr_q;
  logic [15:0] mem_addr_q;
  logic [15:0] mem_wdata_q;
  logic [7:0] io_dev_q;
  logic io_sel_q;
  logic io_strobe_q;
  logic [15:0] io_dout_q;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic [4:0] grp;
  logic [2:0] am;
  logic [15:0] disp;
  logic [15:0] imm;
  logic is_mref;
  logic is_ind;
  logic [15:0] ea;
  logic [15:0] opnd;
  logic [15:0] merged;
  mmd_pkg::mmd_alu_op_t alu_op;
  logic [15:0] alu_a;
  logic [15:0] alu_m;
  logic [15:0] alu_res;
  logic alu_ge;
  logic sense_rise;
  logic last_word;

  assign grp = ir_q[15:11];
  assign am = ir_q[10:8];
  assign disp = {8'h00, ir_q[7:0]};
  assign imm = {{8{ir_q[7]}}, ir_q[7:0]}; // RQ14
  assign sense_rise = sense_s_q & ~sense_d_q;
  assign last_word = (x_q == mmd_pkg::ONE);

  always_comb begin
    is_mref = (grp == mmd_pkg::G_AND) || (grp == mmd_pkg::G_ADD) ||
              (grp == mmd_pkg::G_IOR) || (grp == mmd_pkg::G_XOR) ||
              (grp == mmd_pkg::G_EMA) || (grp == mmd_pkg::G_CMS);
    is_ind = am[0];
    case (am[2:1])
      mmd_pkg::AB_SCRATCH: ea = disp; // RQ2
      mmd_pkg::AB_PC_FWD: ea = p_q + disp; // RQ2
      mmd_pkg::AB_INDEXED: ea = x_q + disp; // RQ2
      default: ea = p_q - disp; // RQ2
    endcase
    // Byte form of code 6 is byte 1, direct, forward from P.
    if (bm_s_q && (am == mmd_pkg::AM_BYTE1)) begin
      ea = p_q + disp; // RQ18
    end
  end

  // Byte operands are zero-extended; exchange merges back one byte only.
  always_comb begin
    if (!bmode_q) begin
      opnd = mem_rdata;
    end else if (bsel_q) begin
      opnd = {8'h00, mem_rdata[15:8]}; // RQ18
    end else begin
      opnd = {8'h00, mem_rdata[7:0]}; // RQ18
    end
    if (bsel_q) begin
      merged = {a_q[7:0], mem_rdata[7:0]};
    end else begin
      merged = {mem_rdata[15:8], a_q[7:0]};
    end
  end

  always_comb begin
    case (grp)
      mmd_pkg::G_AND: alu_op = mmd_pkg::ALU_AND;
      mmd_pkg::G_IOR: alu_op = mmd_pkg::ALU_OR;
      mmd_pkg::G_XOR: alu_op = mmd_pkg::ALU_XOR;
      default: alu_op = mmd_pkg::ALU_ADD;
    endcase
    alu_a = (ir_q[15:8] == mmd_pkg::P_CMP_IDX) ? x_q : a_q;
    alu_m = (state_q == mmd_pkg::ST_EXEC) ? imm : opnd;
  end

  mmd_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .m(alu_m),
    .res(alu_res),
    .m_ge_a(alu_ge)
  );

  // ----------------------------------------------------------------------
  // Sequencer and registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= mmd_pkg::ST_FETCH;
      ir_q <= 16'h0000;
      a_q <= 16'h0000;
      x_q <= 16'h0000;
      p_q <= 16'h0000;
      base_q <= 16'h0000;
      cnt_q <= 3'h0;
      bsel_q <= 1'b0;
      bmode_q <= 1'b0;
      pend_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_addr_q <= 16'h0000;
      mem_wdata_q <= 16'h0000;
      io_dev_q <= 8'h00;
      io_sel_q <= 1'b0;
      io_strobe_q <= 1'b0;
      io_dout_q <= 16'h0000;
    end else if (ce) begin
      io_strobe_q <= 1'b0;
      // A sense edge seen in the cycle it is consumed is kept, not lost.
      if (sense_rise) begin
        pend_q <= 1'b1;
      end
      case (state_q)
        mmd_pkg::ST_FETCH: begin
          mem_addr_q <= p_q;
          mem_rd_q <= 1'b1;
          state_q <= mmd_pkg::ST_FWAIT;
        end
        mmd_pkg::ST_FWAIT: begin
          if (mem_ack) begin
            ir_q <= mem_rdata;
            mem_rd_q <= 1'b0;
            state_q <= mmd_pkg::ST_EXEC;
          end
        end
        mmd_pkg::ST_EXEC: begin
          state_q <= mmd_pkg::ST_FETCH;
          p_q <= p_q + mmd_pkg::ONE;
          if (is_mref) begin
            p_q <= p_q;
            mem_addr_q <= ea; // RQ2
            mem_rd_q <= 1'b1;
            bmode_q <= bm_s_q; // RQ17
            bsel_q <= bm_s_q && (am == mmd_pkg::AM_BYTE1); // RQ18
            state_q <= is_ind ? mmd_pkg::ST_PTR : mmd_pkg::ST_OPND; // RQ2
          end else if (ir_q[15:8] == mmd_pkg::P_CMP_ACC ||
                       ir_q[15:8] == mmd_pkg::P_CMP_IDX) begin
            if (alu_ge) begin
              p_q <= p_q + mmd_pkg::TWO; // RQ14
            end
          end else if (ir_q[15:8] == mmd_pkg::P_ADD_IDX) begin
            x_q <= x_q + imm; // RQ14
          end else if ((ir_q & mmd_pkg::SH_MASK) == mmd_pkg::SH_ACC_L ||
                       (ir_q & mmd_pkg::SH_MASK) == mmd_pkg::SH_ACC_R ||
                       (ir_q & mmd_pkg::SH_MASK) == mmd_pkg::SH_IDX_L ||
                       (ir_q & mmd_pkg::SH_MASK) == mmd_pkg::SH_IDX_R) begin
            cnt_q <= ir_q[2:0]; // RQ13
            state_q <= mmd_pkg::ST_SHIFT;
          end else if (ir_q[15:8] == mmd_pkg::P_BLK_IN ||
                       ir_q[15:8] == mmd_pkg::P_BLK_OUT) begin
            p_q <= p_q;
            io_dev_q <= ir_q[7:0]; // RQ19
            mem_addr_q <= p_q + mmd_pkg::ONE; // RQ21
            mem_rd_q <= 1'b1;
            state_q <= mmd_pkg::ST_BASE;
          end else begin
            // Whole-word match; other words fall through as no-ops.
            case (ir_q) // RQ1
              mmd_pkg::F_MASK_ACC: a_q <= a_q & x_q; // RQ7
              mmd_pkg::F_MASK_IDX: x_q <= a_q & x_q; // RQ7
              mmd_pkg::F_NOR_ACC: a_q <= ~(a_q | x_q); // RQ6
              mmd_pkg::F_NEG_ACC: a_q <= (~a_q) + mmd_pkg::ONE; // RQ10
              mmd_pkg::F_INV_ACC: a_q <= ~a_q; // RQ8 RQ9
              mmd_pkg::F_INV_BOTH: begin
                a_q <= ~a_q; // RQ8
                x_q <= ~x_q;
              end
              mmd_pkg::F_INV_IDX: x_q <= ~x_q; // RQ8
              mmd_pkg::F_INVX_ACC: a_q <= ~x_q; // RQ8
              mmd_pkg::F_ACC_M1: a_q <= 16'hFFFF; // RQ11
              mmd_pkg::F_BOTH_M1: begin
                a_q <= 16'hFFFF; // RQ11
                x_q <= 16'hFFFF;
              end
              mmd_pkg::F_ACC_P1: a_q <= mmd_pkg::ONE; // RQ11
              mmd_pkg::F_BOTH_P1: begin
                a_q <= mmd_pkg::ONE; // RQ11
                x_q <= mmd_pkg::ONE;
              end
              mmd_pkg::F_DEC_ACC: a_q <= a_q - mmd_pkg::ONE; // RQ12
              mmd_pkg::F_DEC_IDX: x_q <= x_q - mmd_pkg::ONE; // RQ12
              mmd_pkg::F_DECA_IDX: x_q <= a_q - mmd_pkg::ONE; // RQ12
              mmd_pkg::F_DECX_ACC: a_q <= x_q - mmd_pkg::ONE; // RQ12
              default: begin
              end
            endcase
          end
        end
        mmd_pkg::ST_PTR: begin
          if (mem_ack) begin
            mem_addr_q <= mem_rdata & mmd_pkg::PTR_ADDR_MASK;
            // Byte forms take a single pointer level, whatever its top bit.
            if (bmode_q || !mem_rdata[mmd_pkg::PTR_CHAIN_BIT]) begin
              state_q <= mmd_pkg::ST_OPND; // RQ17
            end else begin
              state_q <= mmd_pkg::ST_PTR; // RQ23
            end
          end
        end
        mmd_pkg::ST_OPND: begin
          if (mem_ack) begin
            mem_rd_q <= 1'b0;
            state_q <= mmd_pkg::ST_FETCH;
            p_q <= p_q + mmd_pkg::ONE;
            if (grp == mmd_pkg::G_EMA) begin
              a_q <= opnd; // RQ16
              mem_wdata_q <= bmode_q ? merged : a_q; // RQ16
              mem_wr_q <= 1'b1;
              p_q <= p_q;
              state_q <= mmd_pkg::ST_WRITE;
            end else if (grp == mmd_pkg::G_CMS) begin
              if (alu_ge) begin
                p_q <= p_q + mmd_pkg::TWO; // RQ15
              end
            end else begin
              a_q <= alu_res; // RQ3 RQ4 RQ5 RQ22
            end
          end
        end
        mmd_pkg::ST_WRITE: begin
          if (mem_ack) begin
            mem_wr_q <= 1'b0;
            p_q <= p_q + mmd_pkg::ONE;
            state_q <= mmd_pkg::ST_FETCH;
          end
        end
        mmd_pkg::ST_SHIFT: begin
          case (ir_q & mmd_pkg::SH_MASK)
            mmd_pkg::SH_ACC_L: a_q <= {a_q[14:0], 1'b0}; // RQ13
            mmd_pkg::SH_ACC_R: a_q <= {a_q[15], a_q[15:1]}; // RQ13
            mmd_pkg::SH_IDX_L: x_q <= {x_q[14:0], 1'b0}; // RQ13
            default: x_q <= {x_q[15], x_q[15:1]}; // RQ13
          endcase
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h0) begin
            state_q <= mmd_pkg::ST_FETCH;
          end
        end
        mmd_pkg::ST_BASE: begin
          if (mem_ack) begin
            base_q <= mem_rdata; // RQ21
            mem_rd_q <= 1'b0;
            if (x_q == 16'h0000) begin
              p_q <= p_q + mmd_pkg::TWO;
              state_q <= mmd_pkg::ST_FETCH;
            end else begin
              io_sel_q <= 1'b1;
              state_q <= mmd_pkg::ST_SENSE;
            end
          end
        end
        mmd_pkg::ST_SENSE: begin
          // Hold here until the peripheral answers; nothing else advances.
          if (pend_q) begin
            pend_q <= sense_rise;
            mem_addr_q <= base_q + x_q; // RQ21
            if (ir_q[15:8] == mmd_pkg::P_BLK_IN) begin
              mem_wdata_q <= din_s_q; // RQ19
              mem_wr_q <= 1'b1;
              io_strobe_q <= 1'b1;
              state_q <= mmd_pkg::ST_BWR;
            end else begin
              mem_rd_q <= 1'b1; // RQ20
              state_q <= mmd_pkg::ST_BRD;
            end
          end
        end
        mmd_pkg::ST_BRD, mmd_pkg::ST_BWR: begin
          if (mem_ack) begin
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            if (state_q == mmd_pkg::ST_BRD) begin
              io_dout_q <= mem_rdata; // RQ20
              io_strobe_q <= 1'b1; // RQ20
            end
            x_q <= x_q - mmd_pkg::ONE; // RQ21
            if (last_word) begin
              io_sel_q <= 1'b0;
              p_q <= p_q + mmd_pkg::TWO; // RQ21
              state_q <= mmd_pkg::ST_FETCH;
            end else begin
              state_q <= mmd_pkg::ST_SENSE;
            end
          end
        end
        default: state_q <= mmd_pkg::ST_FETCH;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign mem_rd = mem_rd_q;
  assign mem_wr = mem_wr_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign io_dev = io_dev_q;
  assign io_sel = io_sel_q;
  assign io_strobe = io_strobe_q;
  assign io_dout = io_dout_q;
  assign acc = a_q;
  assign idx = x_q;
  assign pc = p_q;

endmodule
`default_nettype wire

// file: dv/mmd_core_asserts.sv
// Purpose: Port-level assertions for the decode and execute block.
// Assumes: One clock; rst_n is asynchronous and active low.
// Notes: Bound onto the core; watches outputs only against their causes.
`default_nettype none
module mmd_core_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic [7:0] io_dev,
  input wire logic io_sel,
  input wire logic io_strobe,
  input wire logic [15:0] io_dout,
  input wire logic [15:0] idx,
  input wire logic [15:0] pc
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Memory bus, block transfer and program counter checks
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd_wait;
    mem_rd && !mem_ack;
  endsequence
  sequence s_wr_wait;
    mem_wr && !mem_ack;
  endsequence
  sequence s_bot_ack;
    mem_rd && mem_ack && io_sel;
  endsequence
  rd_hold_a: assert property (s_rd_wait |=> mem_rd && $stable(mem_addr))
    else $error("read request moved before its ack");
  wr_hold_a: assert property (s_wr_wait |=> mem_wr && $stable({mem_addr, mem_wdata}))
    else $error("write request moved before its ack");
  rw_excl_a: assert property (!(mem_rd && mem_wr))
    else $error("read and write requested together");
  strobe_sel_a: assert property (io_strobe |-> $past(io_sel))
    else $error("word strobe outside a block transfer");
  strobe_gap_a: assert property (io_strobe |=> !io_strobe)
    else $error("two words strobed back to back");
  dout_stand_a: assert property (!io_strobe |-> $stable(io_dout))
    else $error("output word changed without a strobe");
  dev_stand_a: assert property (io_sel && $past(io_sel) |-> $stable(io_dev))
    else $error("device address changed within a transfer");
  bot_word_a: assert property (s_bot_ack |=> io_strobe && io_dout == $past(mem_rdata))
    else $error("output word does not follow the memory read");
  sel_clear_a: assert property ($fell(io_sel) |-> idx == 16'h0000)
    else $error("transfer ended with count not zero");
  pc_step_a: assert property ($changed(pc) |->
    pc == $past(pc) + 16'h0001 || pc == $past(pc) + 16'h0002)
    else $error("program counter moved by other than one or two");
endmodule
bind mmd_core mmd_core_asserts u_chk (.clk, .rst_n, .mem_rd, .mem_wr, .mem_addr,
  .mem_wdata, .mem_rdata, .mem_ack, .io_dev, .io_sel, .io_strobe, .io_dout, .idx, .pc);
`default_nettype wire

// file: dv/mmd_far_model.sv
// Purpose: Memory and peripheral seen from the far side of the core.
// Assumes: 256 words are enough; addresses wrap on the low byte.
// Notes: lat stalls every memory access; it also stretches the sense gap.
`default_nettype none
module mmd_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] lat,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  input wire logic io_sel,
  input wire logic io_strobe,
  input wire logic [15:0] io_dout,
  output logic io_sense,
  output logic [15:0] io_din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [15:0] log_q [0:7];
  logic [1:0] cnt_q;
  logic [2:0] gap_q;
  logic [3:0] n_q;
  // ----------------------------------------------------------------------
  // Memory and peripheral behaviour
  // ----------------------------------------------------------------------
  // Read data outside the ack cycle toggles so stale values never look valid.
  always @(posedge clk) begin
    mem_rdata <= ~mem_rdata;
    io_din <= io_sel ? 16'hA000 + {12'h000, n_q} : ~io_din;
    if (!rst_n) begin
      mem_ack <= 1'b0;
      cnt_q <= 2'h0;
      io_sense <= 1'b0;
      gap_q <= 3'h0;
      n_q <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      if ((mem_rd || mem_wr) && !mem_ack) begin
        if (cnt_q == lat) begin
          mem_ack <= 1'b1;
          cnt_q <= 2'h0;
          if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
          else mem_rdata <= mem[mem_addr[7:0]];
        end else cnt_q <= cnt_q + 2'h1;
      end
      if (io_strobe) begin
        io_sense <= 1'b0;
        gap_q <= 3'h2 + {1'b0, lat};
        log_q[n_q[2:0]] <= io_dout;
        n_q <= n_q + 4'h1;
      end else if (gap_q != 3'h0) gap_q <= gap_q - 3'h1;
      else if (io_sel) io_sense <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: dv/mmd_core_tb_top.sv
// Purpose: Self-checking bench for the decode and execute core.
// Assumes: Programs start at address 0 after each reset.
// Notes: Each scenario reloads memory and resets the core mid-run.
`default_nettype none
module mmd_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic byte_mode = 1'b0;
  logic [1:0] lat = 2'h0;
  logic mem_rd, mem_wr, mem_ack, io_sel, io_strobe, io_sense;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, io_dout, io_din, acc, idx, pc;
  logic [7:0] io_dev;
  int n_errors = 0;
  int checked = 0;
  logic [15:0] prog [$];
  logic [23:0] dat [$];
  logic [47:0] exp_q [$];
  always #5 clk = ~clk;
  mmd_core u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .byte_mode(byte_mode),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .io_dev(io_dev), .io_sel(io_sel),
    .io_strobe(io_strobe), .io_dout(io_dout), .io_sense(io_sense), .io_din(io_din),
    .acc(acc), .idx(idx), .pc(pc));
  mmd_far_model u_far (.clk(clk), .rst_n(rst_n), .lat(lat), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .io_sel(io_sel), .io_strobe(io_strobe), .io_dout(io_dout),
    .io_sense(io_sense), .io_din(io_din));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic boot(input logic bm, input logic [1:0] l);
    @(posedge clk);
    rst_n <= 1'b0;
    byte_mode <= bm;
    lat <= l;
    for (int i = 0; i < 256; i++) u_far.mem[i] = 16'h0000;
    foreach (prog[i]) u_far.mem[i] = prog[i];
    foreach (dat[i]) u_far.mem[dat[i][23:16]] = dat[i][15:0];
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // Waits for the fetch after each expected step, so that a shift has ended.
  task automatic run();
    int k;
    foreach (exp_q[i]) begin
      for (k = 0; k < 400 && !(pc === exp_q[i][47:32] && mem_rd === 1'b1 && mem_addr === pc); k++)
        @(negedge clk);
      if (k == 400) n_errors++;
      check(pc, exp_q[i][47:32]);
      check(acc, exp_q[i][31:16]);
      check(idx, exp_q[i][15:0]);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    prog = {16'h0358, 16'hC204, 16'h0110, 16'h0070, 16'h00A8, 16'h0060, 16'h0068,
      16'h0208, 16'h0408, 16'h0210, 16'h0410, 16'h00C8, 16'h00B0, 16'h00D0, 16'h0018,
      16'h0350, 16'h0010, 16'h0071, 16'h1052, 16'h10D1, 16'h1029, 16'h10A8, 16'hC005,
      16'h0350, 16'hC0FD};
    dat = {};
    exp_q = {48'h0001_0001_0001, 48'h0002_0001_0005, 48'h0003_FFFF_0005,
      48'h0004_0005_0005, 48'h0005_0005_0004, 48'h0006_FFFA_0004, 48'h0007_FFFA_0000,
      48'h0008_0005_FFFF, 48'h0009_0005_0000, 48'h000A_FFFA_0000, 48'h000B_FFFF_0000,
      48'h000C_FFFF_FFFE, 48'h000D_FFFD_FFFE, 48'h000E_FFFC_FFFE, 48'h000F_FFFF_FFFF,
      48'h0010_0001_FFFF, 48'h0011_FFFF_FFFF, 48'h0012_FFFF_FFFF, 48'h0013_FFF8_FFFF,
      48'h0014_FFFE_FFFF, 48'h0015_FFFE_FFFC, 48'h0016_FFFE_FFFE, 48'h0018_FFFE_FFFE,
      48'h0019_FFFE_FFFE};
    boot(1'b0, 2'h0);
    run();
    $display("test registers done");
  endtask
  task automatic t_mem(input logic [1:0] l);
    prog = {16'h0350, 16'h8880, 16'h8081, 16'hA082, 16'hA883, 16'hB884, 16'h8985,
      16'hD088, 16'h0350, 16'hD089};
    dat = {24'h80_1234, 24'h81_0FF0, 24'h82_0006, 24'h83_0232, 24'h84_5555,
      24'h85_8086, 24'h86_0087, 24'h87_0001, 24'h88_6000, 24'h89_0001};
    exp_q = {48'h0001_0001_0000, 48'h0002_1235_0000, 48'h0003_0230_0000,
      48'h0004_0236_0000, 48'h0005_0004_0000, 48'h0006_5555_0000, 48'h0007_5556_0000,
      48'h0009_5556_0000, 48'h000A_5556_0000};
    boot(1'b0, l);
    run();
    check(u_far.mem[8'h84], 16'h0004);
    $display("test memory words done");
  endtask
  task automatic t_byte();
    prog = {16'h8985, 16'h8A10, 16'h8E20};
    dat = {24'h85_8086, 24'h86_C7C7, 24'h11_3C5A, 24'h12_3C5A, 24'h22_3C5A, 24'h23_3C5A};
    exp_q = {48'h0001_00C7_0000, 48'h0002_0121_0000, 48'h0003_015D_0000};
    boot(1'b1, 2'h1);
    run();
    $display("test memory bytes done");
  endtask
  task automatic t_blk();
    prog = {16'hC202, 16'h7105, 16'h0090, 16'hC202, 16'h7506, 16'h00A0, 16'h7107,
      16'h00B0};
    dat = {24'hA1_2222, 24'hA2_1111};
    exp_q = {48'h0001_0000_0002, 48'h0003_0000_0000, 48'h0004_0000_0002,
      48'h0006_0000_0000, 48'h0008_0000_0000};
    boot(1'b0, 2'h2);
    run();
    check(u_far.mem[8'h92], 16'hA000);
    check(u_far.mem[8'h91], 16'hA001);
    check(u_far.log_q[2], 16'h1111);
    check(u_far.log_q[3], 16'h2222);
    check({12'h000, u_far.n_q}, 16'h0004);
    check({8'h00, io_dev}, 16'h0007);
    $display("test block transfer done");
  endtask
  initial begin
    t_regs();
    t_mem(2'h0);
    t_mem(2'h3);
    t_byte();
    t_blk();
    conclude();
  end
  // Every scenario needs under two hundred cycles; this bound is far beyond them.
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
